// >>> testbench/cfg_host_model.sv
// Serial master model for the configuration port; SDA has a pull-up.
// Assumes the bench resolves the wire and feeds it back as line_in.
`timescale 1ns/1ps
module cfg_host_model #(
   parameter logic [6:0] DEV = pmic_regs_pkg::SERIAL_ADDR_DEFAULT
) (
   input  wire logic clk_in,
   input  wire logic line_in,
   output logic      scl_out,
   output logic      sda_out
);
   int nack_count = 0;
   initial {scl_out, sda_out} = 2'b11;
   task automatic step(input logic c, input logic d, input int t);
      scl_out = c;
      sda_out = d;
      repeat (t) @(negedge clk_in);
   endtask : step
   task automatic bitx(input logic b, output logic r);
      step(1'b0, sda_out, 2);
      step(1'b0, b, 3);
      step(1'b1, b, 5);
      r = line_in;
   endtask : bitx
   task automatic xbyte(input logic [7:0] d, input logic chk, output logic [7:0] q);
      logic a;
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(1'b1, a);
      if (chk && a) nack_count++;
   endtask : xbyte
   task automatic halt_frame;
      step(1'b0, sda_out, 2);
      step(1'b0, 1'b0, 3);
      step(1'b1, 1'b0, 5);
      step(1'b1, 1'b1, 5);
   endtask : halt_frame
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      step(1'b1, 1'b0, 5);
      xbyte({DEV, 1'b0}, 1'b1, q);
      xbyte(a, 1'b1, q);
      xbyte(d & 8'h3f, 1'b1, q);
      halt_frame();
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      step(1'b1, 1'b0, 5);
      xbyte({DEV, 1'b0}, 1'b1, q);
      xbyte(a, 1'b1, q);
      step(1'b0, sda_out, 2);
      step(1'b0, 1'b1, 3);
      step(1'b1, 1'b1, 5);
      step(1'b1, 1'b0, 5);
      xbyte({DEV, 1'b1}, 1'b1, q);
      xbyte(8'hff, 1'b0, q);
      halt_frame();
   endtask : rd
endmodule : cfg_host_model

// >>> testbench/watchdog_and_charger_event_regs_tb_top.sv
// Self-checking bench for the watchdog and charger event registers.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps
module watchdog_and_charger_event_regs_tb_top;
   import pmic_regs_pkg::*;
   localparam int unsigned SEC = 40;
   logic       clk = 1'b0, rst_n = 1'b0, guard = 1'b0, en = 1'b0;
   logic [4:0] st = 5'h00;
   logic [1:0] sup = 2'h0;
   logic [3:0] chs = 4'h0;
   logic [2:0] bt = 3'h0;
   logic       scl, hsda, oe, poff, prst;
   logic [7:0] q;
   int         n, fail_count = 0, tests_run = 0, cycles = 0;
   watchdog_and_charger_event_regs #(.SECOND_CYCLES(SEC)) dut_u (.SYS_CLK_IN(clk), .RESETN_IN(rst_n),
      .SCL_IN(scl), .SDA_IN(hsda & ~oe), .SDA_OUT(), .SDA_OE_OUT(oe), .OTP_DISABLE_GUARD_IN(guard),
      .OTP_DOG_ENABLE_IN(en), .SYSV_LOOP_STATUS_IN(st[0]), .INPUT_VOLTAGE_LOOP_STATUS_IN(st[1]),
      .INPUT_CURRENT_LOOP_STATUS_IN(st[2]), .DIE_THERMAL_LOOP_STATUS_IN(st[3]), .INPUT_SUPPLY_DETAILS_IN(sup),
      .CHARGER_STATE_DETAILS_IN(chs), .BATTERY_TEMP_DETAILS_IN(bt), .SYSV_CONFIG_FORCED_IN(st[4]),
      .POWER_OFF_REQ_OUT(poff), .POWER_RESET_REQ_OUT(prst));
   cfg_host_model host_u (.clk_in(clk), .line_in(hsda & ~oe), .scl_out(scl), .sda_out(hsda));
   initial forever #50 clk = ~clk;
   task automatic stop_test;
      $display("Counts: %0d checks, %0d mismatches", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : stop_test
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic win(input string what, input int t, input int got);
      tests_run++;
      if (got > t || got + 60 <= t) begin
         fail_count++;
         $display("Error %s expected %0d seen %0d", what, t, got);
      end
   endtask : win
   task automatic watch(input int lim, output int k);
      k = 0;
      while (poff !== 1'b1 && prst !== 1'b1 && k < lim) begin
         @(negedge clk);
         k++;
      end
   endtask : watch
   task automatic poke(input int k);
      @(negedge clk);
      case (k)
         0: bt ^= 3'h1;
         1: chs ^= 4'h1;
         2: sup ^= 2'h1;
         3: st[3] = ~st[3];
         4: st[1] = ~st[1];
         5: st[2] = ~st[2];
         6: st[0] = ~st[0];
         default: st[4] = 1'b1;
      endcase
      @(negedge clk);
      st[4] = 1'b0;
   endtask : poke
   task automatic restart(input logic g);
      @(negedge clk);
      rst_n = 1'b0;
      {guard, en} = {g, g};
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (5) @(negedge clk);
   endtask : restart
   initial begin
      restart(1'b0);
      host_u.rd(ADDR_DOG_CONFIG, q);
      check("config reset", 8'h30, q);
      host_u.rd(8'h05, q);
      check("unmapped", 8'h00, q);
      $display("test reset done");
      for (int s = 0; s < 4; s++) begin
         host_u.wr(ADDR_DOG_CONFIG, {2'h0, 2'(s), 1'(s), 3'h2});
         watch(6000, n);
         win("period", (16 << s) * SEC, n);
         check("action", {6'h0, 1'(s), ~1'(s)}, {6'h0, prst, poff});
      end
      $display("test expiry done");
      host_u.wr(ADDR_DOG_CONFIG, 8'h02);
      repeat (150) @(negedge clk);
      host_u.wr(ADDR_DOG_CONFIG, 8'h06);
      watch(1000, n);
      win("feed period", 16 * SEC, n);
      host_u.wr(ADDR_DOG_CONFIG, 8'h02);
      watch(1000, n);
      win("plain write", 16 * SEC - 285, n);
      host_u.rd(ADDR_DOG_CONFIG, q);
      check("feed clears", 8'h02, q);
      host_u.wr(ADDR_DOG_CONFIG, 8'h00);
      host_u.rd(ADDR_DOG_CONFIG, q);
      check("enable cleared", 8'h00, q);
      watch(800, n);
      win("disabled", 800, n);
      $display("test feed done");
      for (int k = 0; k < 9; k++) begin
         if (k < 8) poke(k);
         host_u.rd(ADDR_EVENT_FLAGS, q);
         check("flags", (k < 8) ? 8'h01 << (k - int'(k > 4)) : 8'h00, q);
      end
      $display("test events done");
      restart(1'b1);
      host_u.rd(ADDR_DOG_CONFIG, q);
      check("strap reset", 8'h33, q);
      host_u.wr(ADDR_DOG_CONFIG, 8'h30);
      host_u.rd(ADDR_DOG_CONFIG, q);
      check("guarded", 8'h33, q);
      check("acks", 8'h00, host_u.nack_count[7:0]);
      $display("test guard done");
      stop_test();
   end
endmodule : watchdog_and_charger_event_regs_tb_top

// >>> testbench/wd_event_checker.sv
// Port-level checks on the watchdog and event register block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
module wd_event_checker #(
   parameter int unsigned SECOND_CYCLES = 10
) (
   input wire logic SYS_CLK_IN,
   input wire logic RESETN_IN,
   input wire logic SCL_IN,
   input wire logic SDA_OUT,
   input wire logic SDA_OE_OUT,
   input wire logic POWER_OFF_REQ_OUT,
   input wire logic POWER_RESET_REQ_OUT
);
   localparam int unsigned MIN_GAP = 16 * SECOND_CYCLES;
   int unsigned gap;
   int unsigned next_gap;
   logic        pulse;
   assign pulse = POWER_OFF_REQ_OUT | POWER_RESET_REQ_OUT;
   always_comb next_gap = pulse ? 0 : ((gap < MIN_GAP) ? gap + 1 : gap);
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) gap <= 0;
      else gap <= next_gap;
   end
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   sequence quiet_s;
      (!SDA_OE_OUT && !pulse) [*3];
   endsequence
   off_single_a: assert property (POWER_OFF_REQ_OUT |=> !pulse)
      else $error("off request not single");
   rst_single_a: assert property (POWER_RESET_REQ_OUT |=> !pulse)
      else $error("reset request not single");
   action_excl_a: assert property (!(POWER_OFF_REQ_OUT && POWER_RESET_REQ_OUT))
      else $error("both requests at once");
   min_period_a: assert property (pulse |-> gap >= MIN_GAP - 1)
      else $error("expiry sooner than shortest period");
   sda_low_a: assert property (SDA_OUT == 1'b0)
      else $error("data pin driven high");
   oe_scl_low_a: assert property ($changed(SDA_OE_OUT) |-> !SCL_IN && !$past(SCL_IN))
      else $error("data changed while clock high");
   ack_hold_a: assert property ($rose(SDA_OE_OUT) |=> SDA_OE_OUT [*4])
      else $error("pull-down too short");
   start_quiet_a: assert property ($rose(RESETN_IN) |-> quiet_s)
      else $error("activity right after reset");
endmodule : wd_event_checker

bind watchdog_and_charger_event_regs wd_event_checker #(.SECOND_CYCLES(SECOND_CYCLES)) chk_u (.SYS_CLK_IN,
   .RESETN_IN, .SCL_IN, .SDA_OUT, .SDA_OE_OUT, .POWER_OFF_REQ_OUT, .POWER_RESET_REQ_OUT);

// >>> verilog/cfg_bus_if.sv
// Byte-wide register access path between the serial port and the
// register bank. rdata is combinational from addr.
`timescale 1ns/1ps
interface cfg_bus_if;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       wr_stb;
   logic       rd_stb;

   modport host_side (output addr, output wdata, output wr_stb, output rd_stb, input rdata);
   modport regs_side (input addr, input wdata, input wr_stb, input rd_stb, output rdata);
endinterface : cfg_bus_if

// >>> verilog/cfg_serial_slave.sv
// Two-wire serial slave: device address, register pointer, then
// data bytes with pointer auto-increment for writes and reads.
// Assumes pins from outside the clock domain; SDA is open drain.
`timescale 1ns/1ps
module cfg_serial_slave #(
   parameter logic [6:0] DEV_ADDR = pmic_regs_pkg::SERIAL_ADDR_DEFAULT
) (
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   cfg_bus_if.host_side bus
);
   import pmic_regs_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   logic [2:0]    scl_sync, sda_sync;
   serial_state_t state, next_state;
   byte_kind_t    kind, next_kind;
   logic [3:0]    bitcnt, next_bitcnt;
   logic [7:0]    shreg, next_shreg;
   logic [7:0]    ptr, next_ptr;
   logic          rw, next_rw;
   logic          drive, next_drive;
   logic          scl_rise, scl_fall, start_cond, stop_cond;

   assign scl_rise   = scl_sync[1] & ~scl_sync[2];
   assign scl_fall   = ~scl_sync[1] & scl_sync[2];
   assign start_cond = scl_sync[1] & scl_sync[2] & sda_sync[2] & ~sda_sync[1];
   assign stop_cond  = scl_sync[1] & scl_sync[2] & ~sda_sync[2] & sda_sync[1];

   assign bus.addr   = ptr;
   assign bus.wdata  = shreg;
   assign sda_out    = 1'b0;
   assign sda_oe_out = drive;

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_state  = state;
      next_kind   = kind;
      next_bitcnt = bitcnt;
      next_shreg  = shreg;
      next_ptr    = ptr;
      next_rw     = rw;
      next_drive  = drive;
      bus.wr_stb  = 1'b0;
      bus.rd_stb  = 1'b0;
      if (start_cond) begin
         next_state  = SER_RX;
         next_kind   = KIND_ADDR;
         next_bitcnt = 4'h0;
         next_drive  = 1'b0;
      end else if (stop_cond) begin
         next_state = SER_IDLE;
         next_drive = 1'b0;
      end else begin
         case (state)
            SER_RX: begin
               if (scl_rise) begin
                  next_shreg  = {shreg[6:0], sda_sync[1]};
                  next_bitcnt = bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == 4'h8) begin
                  next_bitcnt = 4'h0;
                  next_state  = SER_RACK;
                  next_drive  = 1'b1;
                  case (kind)
                     KIND_ADDR: begin
                        next_rw = shreg[0];
                        if (shreg[7:1] != DEV_ADDR) begin
                           next_state = SER_IDLE;
                           next_drive = 1'b0;
                        end
                     end
                     KIND_PTR: next_ptr = shreg;
                     default: begin
                        bus.wr_stb = 1'b1;
                        next_ptr   = ptr + 8'h01;
                     end
                  endcase
               end
            end
            SER_RACK: begin
               if (scl_fall) begin
                  if (kind == KIND_ADDR && rw) begin
                     bus.rd_stb  = 1'b1;
                     next_shreg  = bus.rdata;
                     next_ptr    = ptr + 8'h01;
                     next_drive  = ~bus.rdata[7];
                     next_bitcnt = 4'h1;
                     next_state  = SER_TX;
                  end else begin
                     next_drive = 1'b0;
                     next_state = SER_RX;
                     next_kind  = (kind == KIND_ADDR) ? KIND_PTR : KIND_DATA;
                  end
               end
            end
            SER_TX: begin
               if (scl_fall) begin
                  if (bitcnt == 4'h8) begin
                     next_drive = 1'b0;
                     next_state = SER_TACK;
                  end else begin
                     next_shreg  = {shreg[6:0], 1'b0};
                     next_drive  = ~shreg[6];
                     next_bitcnt = bitcnt + 4'h1;
                  end
               end
            end
            SER_TACK: begin
               if (scl_rise && sda_sync[1]) begin
                  next_state = SER_IDLE;
               end else if (scl_fall) begin
                  bus.rd_stb  = 1'b1;
                  next_shreg  = bus.rdata;
                  next_ptr    = ptr + 8'h01;
                  next_drive  = ~bus.rdata[7];
                  next_bitcnt = 4'h1;
                  next_state  = SER_TX;
               end
            end
            default: next_drive = 1'b0;
         endcase
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         state    <= SER_IDLE;
         kind     <= KIND_ADDR;
         bitcnt   <= 4'h0;
         shreg    <= 8'h00;
         ptr      <= 8'h00;
         rw       <= 1'b0;
         drive    <= 1'b0;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         state    <= next_state;
         kind     <= next_kind;
         bitcnt   <= next_bitcnt;
         shreg    <= next_shreg;
         ptr      <= next_ptr;
         rw       <= next_rw;
         drive    <= next_drive;
      end
   end

endmodule : cfg_serial_slave

// >>> verilog/dog_timer.sv
// Watchdog countdown: one-second enable from a divider, counts the
// selected number of seconds, pulses expire_out for one cycle.
// Assumes restart_in and enable_in come from the same clock.
`timescale 1ns/1ps
module dog_timer #(
   parameter int unsigned SEC_CYCLES = pmic_regs_pkg::SECOND_CYCLES
) (
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic       enable_in,
   input  wire logic       restart_in,
   input  wire logic [1:0] sel_in,
   output logic            expire_out
);
   import pmic_regs_pkg::*;

   localparam int unsigned DIV_W = (SEC_CYCLES > 1) ? $clog2(SEC_CYCLES) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SEC_CYCLES - 1);

   logic [DIV_W-1:0] div, next_div;
   logic [7:0]       secs, next_secs;
   logic             next_expire;

   // ----------------------------------------
   // Countdown
   // ----------------------------------------
   always_comb begin
      next_div    = div;
      next_secs   = secs;
      next_expire = 1'b0;
      if (!enable_in || restart_in) begin
         next_div  = '0;
         next_secs = timeout_seconds(sel_in);
      end else if (div == DIV_LAST) begin
         next_div = '0;
         if (secs == 8'h01) begin
            next_expire = 1'b1;
            next_secs   = timeout_seconds(sel_in);
         end else begin
            next_secs = secs - 8'h01;
         end
      end else begin
         next_div = div + DIV_W'(1);
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div        <= '0;
         secs       <= TIMEOUT_S_128;
         expire_out <= 1'b0;
      end else begin
         div        <= next_div;
         secs       <= next_secs;
         expire_out <= next_expire;
      end
   end

endmodule : dog_timer

// >>> verilog/pmic_regs_pkg.sv
// Register map, field layout, reset values and timing for the
// watchdog and charger event register block.
// Assumes a 10 MHz system clock.
package pmic_regs_pkg;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h01;
   localparam logic [7:0] ADDR_DOG_CONFIG  = 8'h17;

   // ----------------------------------------
   // Watchdog config fields
   // ----------------------------------------
   localparam int unsigned POS_GUARD  = 0;
   localparam int unsigned POS_ENABLE = 1;
   localparam int unsigned POS_FEED   = 2;
   localparam int unsigned POS_ACTION = 3;
   localparam int unsigned POS_SEL_LO = 4;
   localparam int unsigned POS_SEL_HI = 5;
   localparam int unsigned POS_RSV_LO = 6;
   localparam int unsigned POS_RSV_HI = 7;

   localparam logic [1:0] RESET_RSV    = 2'h0;
   localparam logic [1:0] RESET_SEL    = 2'h3;
   localparam logic       RESET_ACTION = 1'h0;
   localparam logic       RESET_FEED   = 1'h0;

   // ----------------------------------------
   // Event flag positions
   // ----------------------------------------
   localparam int unsigned EV_BATT_TEMP = 0;
   localparam int unsigned EV_CHG_STATE = 1;
   localparam int unsigned EV_IN_DTLS   = 2;
   localparam int unsigned EV_THERMAL   = 3;
   localparam int unsigned EV_IN_LOOP   = 4;
   localparam int unsigned EV_SYSV_LOOP = 5;
   localparam int unsigned EV_SYSV_CFG  = 6;
   localparam int unsigned EV_COUNT     = 7;

   localparam logic [6:0] RESET_EVENTS = 7'h00;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned SECOND_NS     = 1000000000;
   localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

   localparam logic [7:0] TIMEOUT_S_16  = 8'h10;
   localparam logic [7:0] TIMEOUT_S_32  = 8'h20;
   localparam logic [7:0] TIMEOUT_S_64  = 8'h40;
   localparam logic [7:0] TIMEOUT_S_128 = 8'h80;

   // Bus address on the serial port, value arbitrary
   localparam logic [6:0] SERIAL_ADDR_DEFAULT = 7'h2a;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      SER_IDLE = 3'h0,
      SER_RX   = 3'h1,
      SER_RACK = 3'h3,
      SER_TX   = 3'h2,
      SER_TACK = 3'h6
   } serial_state_t;

   typedef enum logic [1:0] {
      KIND_ADDR = 2'h0,
      KIND_PTR  = 2'h1,
      KIND_DATA = 2'h3
   } byte_kind_t;

   function automatic logic [7:0] timeout_seconds(input logic [1:0] sel);
      case (sel)
         2'h0:    timeout_seconds = TIMEOUT_S_16;
         2'h1:    timeout_seconds = TIMEOUT_S_32;
         2'h2:    timeout_seconds = TIMEOUT_S_64;
         default: timeout_seconds = TIMEOUT_S_128;
      endcase
   endfunction : timeout_seconds

endpackage : pmic_regs_pkg

// >>> verilog/watchdog_and_charger_event_regs.sv
// Watchdog configuration and charger event registers behind the
// two-wire configuration port.
// Assumes status inputs come from analog blocks (asynchronous) and
// the forced-config pulse from logic on SYS_CLK_IN.
//
// Behaviour
// (RULE_01) Select codes 0..3 give 16, 32, 64, 128 second timeouts.
// (RULE_02) Writing a different timeout select restarts the countdown at once.
// (RULE_03) On expiry: action bit 0 powers off, 1 power-resets.
// (RULE_04) Writing 1 to feed reloads full period; writing 0 does nothing.
// (RULE_05) Enabled watchdog counts down and expires unfed; disabled never expires.
// (RULE_06) Guard set blocks clearing enable but still allows setting it.
// (RULE_07) Guard is read-only factory value; enable resets to factory value.
// (RULE_08) Host writes reserved bits as zero; their read value is don't care.
// (RULE_09) Event flags reset 0, latch on event, read returns then clears all.
// (RULE_10) Bit 6 sets when charge-voltage setting is forcibly altered.
// (RULE_11) Bit 5 sets when system minimum-voltage loop status changes.
// (RULE_12) Bit 4 sets when input voltage or current loop status changes.
// (RULE_13) Bit 3 sets when die thermal regulation status changes.
// (RULE_14) Bit 2 sets when two-bit input supply details change.
// (RULE_15) Bit 1 sets when four-bit charger state details change.
// (RULE_16) Bit 0 sets when three-bit battery temperature details change.
// (RULE_17) Feed bit clears itself after one reload.
// (RULE_18) Expiry gives one-cycle request; event during clearing read stays latched.
`timescale 1ns/1ps
module watchdog_and_charger_event_regs #(
   parameter int unsigned SECOND_CYCLES = pmic_regs_pkg::SECOND_CYCLES,
   parameter logic [6:0]  DEV_ADDR      = pmic_regs_pkg::SERIAL_ADDR_DEFAULT
) (
   input  wire logic       SYS_CLK_IN,
   input  wire logic       RESETN_IN,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_OUT,
   input  wire logic       OTP_DISABLE_GUARD_IN,
   input  wire logic       OTP_DOG_ENABLE_IN,
   input  wire logic       SYSV_LOOP_STATUS_IN,
   input  wire logic       INPUT_VOLTAGE_LOOP_STATUS_IN,
   input  wire logic       INPUT_CURRENT_LOOP_STATUS_IN,
   input  wire logic       DIE_THERMAL_LOOP_STATUS_IN,
   input  wire logic [1:0] INPUT_SUPPLY_DETAILS_IN,
   input  wire logic [3:0] CHARGER_STATE_DETAILS_IN,
   input  wire logic [2:0] BATTERY_TEMP_DETAILS_IN,
   input  wire logic       SYSV_CONFIG_FORCED_IN,
   output logic            POWER_OFF_REQ_OUT,
   output logic            POWER_RESET_REQ_OUT
);
   import pmic_regs_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   cfg_bus_if bus ();

   logic [14:0] pin_meta, pin_sync;
   logic [12:0] status_now, status_prev;
   logic        primed, next_primed;
   logic [1:0]  strap_cnt, next_strap_cnt;

   logic [1:0]  rsv, next_rsv;
   logic [1:0]  sel, next_sel;
   logic        action, next_action;
   logic        feed, next_feed;
   logic        dog_en, next_dog_en;
   logic        guard, next_guard;
   logic        restart, next_restart;
   logic        expire;
   logic        next_off, next_rst;

   logic [6:0]  flags, next_flags;
   logic [6:0]  ev_set;
   logic        cfg_wr, flags_rd;
   logic [7:0]  cfg_read;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         pin_meta <= 15'h0000;
         pin_sync <= 15'h0000;
      end else begin
         pin_meta <= {OTP_DISABLE_GUARD_IN, OTP_DOG_ENABLE_IN,
                      SYSV_LOOP_STATUS_IN, INPUT_VOLTAGE_LOOP_STATUS_IN,
                      INPUT_CURRENT_LOOP_STATUS_IN, DIE_THERMAL_LOOP_STATUS_IN,
                      INPUT_SUPPLY_DETAILS_IN, CHARGER_STATE_DETAILS_IN,
                      BATTERY_TEMP_DETAILS_IN};
         pin_sync <= pin_meta;
      end
   end

   assign status_now = pin_sync[12:0];

   // ----------------------------------------
   // Serial port and watchdog counter
   // ----------------------------------------
   cfg_serial_slave #(
      .DEV_ADDR   (DEV_ADDR)
   ) u_serial (
      .clk_in     (SYS_CLK_IN),
      .resetn_in  (RESETN_IN),
      .scl_in     (SCL_IN),
      .sda_in     (SDA_IN),
      .sda_out    (SDA_OUT),
      .sda_oe_out (SDA_OE_OUT),
      .bus        (bus.host_side)
   );

   dog_timer #(
      .SEC_CYCLES (SECOND_CYCLES)
   ) u_dog (
      .clk_in     (SYS_CLK_IN),
      .resetn_in  (RESETN_IN),
      .enable_in  (dog_en),     // RULE_05
      .restart_in (restart),
      .sel_in     (sel),        // RULE_01
      .expire_out (expire)
   );

   // ----------------------------------------
   // Register decode
   // ----------------------------------------
   assign cfg_wr   = bus.wr_stb && bus.addr == ADDR_DOG_CONFIG;
   assign flags_rd = bus.rd_stb && bus.addr == ADDR_EVENT_FLAGS;

   always_comb begin
      cfg_read                        = 8'h00;
      cfg_read[POS_RSV_HI:POS_RSV_LO] = rsv;   // RULE_08
      cfg_read[POS_SEL_HI:POS_SEL_LO] = sel;
      cfg_read[POS_ACTION]            = action;
      cfg_read[POS_FEED]              = feed;
      cfg_read[POS_ENABLE]            = dog_en;
      cfg_read[POS_GUARD]             = guard;
   end

   always_comb begin
      case (bus.addr)
         ADDR_EVENT_FLAGS: bus.rdata = {1'b0, flags};
         ADDR_DOG_CONFIG:  bus.rdata = cfg_read;
         default:          bus.rdata = 8'h00;
      endcase
   end

   // ----------------------------------------
   // Watchdog configuration
   // ----------------------------------------
   always_comb begin
      next_strap_cnt = strap_cnt;
      next_rsv       = rsv;
      next_sel       = sel;
      next_action    = action;
      next_feed      = 1'b0;                    // RULE_17
      next_dog_en    = dog_en;
      next_guard     = guard;
      next_restart   = feed;                    // RULE_04
      if (strap_cnt != 2'h3) begin
         next_strap_cnt = strap_cnt + 2'h1;
         if (strap_cnt == 2'h2) begin
            next_guard  = pin_sync[14];         // RULE_07
            next_dog_en = pin_sync[13];         // RULE_07
         end
      end else if (cfg_wr) begin
         next_rsv    = bus.wdata[POS_RSV_HI:POS_RSV_LO];
         next_sel    = bus.wdata[POS_SEL_HI:POS_SEL_LO];
         next_action = bus.wdata[POS_ACTION];
         next_feed   = bus.wdata[POS_FEED];     // RULE_04
         if (next_sel != sel) begin
            next_restart = 1'b1;                // RULE_02
         end
         if (bus.wdata[POS_ENABLE]) begin
            next_dog_en = 1'b1;
         end else if (!guard) begin
            next_dog_en = 1'b0;                 // RULE_06
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         strap_cnt <= 2'h0;
         rsv       <= RESET_RSV;
         sel       <= RESET_SEL;
         action    <= RESET_ACTION;
         feed      <= RESET_FEED;
         dog_en    <= 1'b0;
         guard     <= 1'b0;
         restart   <= 1'b0;
      end else begin
         strap_cnt <= next_strap_cnt;
         rsv       <= next_rsv;
         sel       <= next_sel;
         action    <= next_action;
         feed      <= next_feed;
         dog_en    <= next_dog_en;
         guard     <= next_guard;
         restart   <= next_restart;
      end
   end

   // ----------------------------------------
   // Expiry requests
   // ----------------------------------------
   always_comb begin
      next_off = expire && !action;             // RULE_03 RULE_18
      next_rst = expire && action;              // RULE_03 RULE_18
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         POWER_OFF_REQ_OUT   <= 1'b0;
         POWER_RESET_REQ_OUT <= 1'b0;
      end else begin
         POWER_OFF_REQ_OUT   <= next_off;
         POWER_RESET_REQ_OUT <= next_rst;
      end
   end

   // ----------------------------------------
   // Charger event flags
   // ----------------------------------------
   always_comb begin
      ev_set               = 7'h00;
      ev_set[EV_SYSV_CFG]  = SYSV_CONFIG_FORCED_IN;                     // RULE_10
      ev_set[EV_SYSV_LOOP] = status_now[12] != status_prev[12];         // RULE_11
      ev_set[EV_IN_LOOP]   = status_now[11:10] != status_prev[11:10];   // RULE_12
      ev_set[EV_THERMAL]   = status_now[9] != status_prev[9];           // RULE_13
      ev_set[EV_IN_DTLS]   = status_now[8:7] != status_prev[8:7];       // RULE_14
      ev_set[EV_CHG_STATE] = status_now[6:3] != status_prev[6:3];       // RULE_15
      ev_set[EV_BATT_TEMP] = status_now[2:0] != status_prev[2:0];       // RULE_16
      if (!primed) begin
         ev_set[EV_SYSV_LOOP:EV_BATT_TEMP] = 6'h00;
      end
      next_primed = primed | (strap_cnt == 2'h2);
      next_flags  = (flags_rd ? RESET_EVENTS : flags) | ev_set;         // RULE_09 RULE_18
   end

   always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         flags       <= RESET_EVENTS;                                   // RULE_09
         status_prev <= 13'h0000;
         primed      <= 1'b0;
      end else begin
         flags       <= next_flags;
         status_prev <= status_now;
         primed      <= next_primed;
      end
   end

endmodule : watchdog_and_charger_event_regs
